// [rtl/hdr_rate_pkg.sv]
// constants, types and register map of the high data rate framer
package hdr_rate_pkg;
  localparam int CLK_MHZ = 25;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FBCMD  = 8'h08;
  localparam logic [7:0] REG_FBDATA = 8'h0c;
  localparam logic [7:0] REG_TXCTRL = 8'h10;
  // register field positions
  localparam int CTRL_RATE_LSB  = 0;
  localparam int CTRL_SCRAM_BIT = 5;
  localparam int CTRL_THR_LSB   = 8;
  localparam int CTRL_AACK_BIT  = 16;
  localparam int CTRL_SACK_BIT  = 17;
  localparam int CTRL_CCA_LSB   = 18;
  localparam int TXCTRL_GO_BIT  = 8;
  localparam int FBDATA_VLD_BIT = 8;
  // values after reset and fixed field codes
  localparam logic [1:0] RATE_RESET  = 2'h0;
  localparam logic       SCRAM_RESET = 1'b1;
  localparam logic [1:0] CCA_ENERGY  = 2'h1;
  localparam logic [1:0] CCA_RESET   = 2'h1;
  localparam logic [1:0] RATE_2000   = 2'h3;
  localparam logic [2:0] FB_READ_CMD = 3'h1;
  // frame content
  localparam int         SHR_OCTETS = 5;
  localparam logic [7:0] PREAMBLE   = 8'h00;
  localparam logic [7:0] SFD_BYTE   = 8'ha7;
  localparam logic [6:0] ACK_LEN    = 7'h05;
  localparam logic [7:0] ACK_FC0    = 8'h02;
  localparam logic [7:0] LQI_FILL   = 8'hff;
  // times and derived cycle counts
  localparam int OCTET_STD_US = 32;
  localparam int ED_STD_US    = 128;
  localparam int ED_HDR_US    = 32;
  localparam int ACK_STD_US   = 192;
  localparam int ACK_SHORT_US = 32;
  localparam int OCTET_STD_CYC = OCTET_STD_US * CLK_MHZ;
  localparam int ED_STD_CYC    = ED_STD_US * CLK_MHZ;
  localparam int ED_HDR_CYC    = ED_HDR_US * CLK_MHZ;
  localparam int ACK_STD_CYC   = ACK_STD_US * CLK_MHZ;
  localparam int ACK_SHORT_CYC = ACK_SHORT_US * CLK_MHZ;
  localparam int TMR_W = 13;

  typedef struct packed {
    logic       hdrDet;
    logic [6:0] frameLen;
    logic [3:0] rssi;
    logic       octValid;
    logic [7:0] octData;
    logic       frameEnd;
    logic       crcOk;
    logic       payloadWeak;
    logic       ackReq;
    logic [7:0] seqNum;
    logic [7:0] edLevel;
  } rx_in_t;

  typedef struct packed {
    logic       octStrobe;
    logic [7:0] octData;
    logic       payloadPhase;
    logic       isAck;
  } tx_out_t;

  typedef struct packed {
    logic [1:0] rate;
    logic       scramble;
    logic [1:0] ccaMode;
    logic       edWindow;
  } phy_cfg_t;
endpackage

// [rtl/hdr_rate_framer.sv]
// high data rate framer: registers, tx sequencer, rx store, buffer read and fifo
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wrPtr_r;
  logic [AW:0]  rdPtr_r;
  wire          full  = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire          empty = wrPtr_r == rdPtr_r;
  wire          push  = inValid && !full;
  wire          pop   = outReady && !empty;

  generate
    if (D < 2 || (1 << AW) != D)
    begin : g_chk
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + (AW+1)'(push);
      rdPtr_r <= rdPtr_r + (AW+1)'(pop);
    end
  end
endmodule

`timescale 1ns/10ps
module hdr_rate_framer #(
  parameter int ACK_STD_CYC = hdr_rate_pkg::ACK_STD_CYC,
  parameter int FIFO_DEPTH  = 4
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [31:0]          dat_i,
  input  wire logic [3:0]           sel_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  // receiver events
  input  wire hdr_rate_pkg::rx_in_t rxIn,
  // transmit payload byte from host side buffer
  input  wire logic [7:0]           txPayloadData,
  output hdr_rate_pkg::tx_out_t     txOut,
  // modem configuration
  output hdr_rate_pkg::phy_cfg_t    phyCfg
);
  typedef enum logic [1:0] {TX_IDLE, TX_SHR, TX_PHR, TX_PAY} tx_state_t;
  typedef enum logic [2:0] {RD_IDLE, RD_STAT, RD_PHR, RD_PAY, RD_LQI, RD_ED, RD_RXS} rd_state_t;

  generate
    if (ACK_STD_CYC < 1 || ACK_STD_CYC >= (1 << hdr_rate_pkg::TMR_W))
    begin : g_chk
      $error("ack time does not fit the timer");
    end
  endgenerate

  // control and status state
  logic [1:0]  rate_r;
  logic        scramEn_r;
  logic [3:0]  thr_r;
  logic        autoAck_r;
  logic        shortAck_r;
  logic [1:0]  ccaMode_r;
  logic [7:0]  rejectCnt_r;
  logic [7:0]  edVal_r;
  logic        frameValid_r;
  logic        rxActive_r;
  logic [7:0]  rxStatus_r;
  logic [6:0]  rxLen_r;
  logic [6:0]  wrIdx_r;
  logic [7:0]  fb [128];
  logic [12:0] edTmr_r;
  logic        edOn_r;
  logic        ackPend_r;
  logic [12:0] ackTmr_r;
  logic [7:0]  ackSeq_r;
  logic [31:0] dat_r;
  logic        ack_r;

  // wishbone decode
  wire         wbReq    = cyc_i && stb_i && !ack_r;
  wire         wbWr     = cyc_i && stb_i && we_i && ack_r;
  wire         wbRd     = wbReq && !we_i;
  wire         selCtrl  = adr_i == hdr_rate_pkg::REG_CTRL;
  wire         selStat  = adr_i == hdr_rate_pkg::REG_STATUS;
  wire         selCmd   = adr_i == hdr_rate_pkg::REG_FBCMD;
  wire         selData  = adr_i == hdr_rate_pkg::REG_FBDATA;
  wire         selTx    = adr_i == hdr_rate_pkg::REG_TXCTRL;
  wire         wrCtrl0  = wbWr && selCtrl && sel_i[0];
  wire         wrCtrl1  = wbWr && selCtrl && sel_i[1];
  wire         wrCtrl2  = wbWr && selCtrl && sel_i[2];
  wire [2:0]   rateWr   = dat_i[hdr_rate_pkg::CTRL_RATE_LSB +: 3];
  wire         rateOk   = rateWr[2] == 1'b0;
  wire         highRate = rate_r != hdr_rate_pkg::RATE_RESET;

  // fifo link
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [7:0]  fifoOutData;
  wire         popData = wbRd && selData;

  // tx sequencer state
  tx_state_t   txState_r;
  logic [2:0]  shrCnt_r;
  logic [6:0]  txLen_r;
  logic [6:0]  txIdx_r;
  logic        txAck_r;
  logic [12:0] octTmr_r;
  wire         txBusy   = txState_r != TX_IDLE;
  wire         hostGo   = wbWr && selTx && &sel_i[1:0] && dat_i[hdr_rate_pkg::TXCTRL_GO_BIT];
  wire         ackFire  = ackPend_r && ackTmr_r == 13'h0001 && !txBusy;
  wire         octDue   = octTmr_r == 13'h0000;

  // octet period: headers at the standard rate, payload at the chosen one
  wire [12:0]  stdOct   = 13'(hdr_rate_pkg::OCTET_STD_CYC);
  wire [12:0]  payOct   = stdOct >> rate_r;
  wire         nextPay  = txState_r == TX_PHR || (txState_r == TX_PAY && txIdx_r != txLen_r);
  wire [12:0]  octLoad  = (nextPay ? payOct : stdOct) - 13'h0001;

  function automatic logic [7:0] ackByte(input logic [6:0] idx, input logic [7:0] seq);
    logic [7:0] b;
    b = 8'h00;
    if (idx == 7'h00)
    begin
      b = hdr_rate_pkg::ACK_FC0;
    end
    else if (idx == 7'h02)
    begin
      b = seq;
    end
    return b;
  endfunction

  wire [7:0]   payByte  = txAck_r ? ackByte(txIdx_r, ackSeq_r) : txPayloadData;
  wire [7:0]   shrByte  = shrCnt_r == 3'(hdr_rate_pkg::SHR_OCTETS - 1) ? hdr_rate_pkg::SFD_BYTE
                                                                        : hdr_rate_pkg::PREAMBLE;
  // header holds the length only, no rate indication
  wire [7:0]   phrByte  = {1'b0, txLen_r};

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      txState_r <= TX_IDLE;
      shrCnt_r  <= '0;
      txLen_r   <= '0;
      txIdx_r   <= '0;
      txAck_r   <= 1'b0;
      octTmr_r  <= '0;
      txOut     <= '0;
    end
    else
    begin
      txOut.octStrobe <= 1'b0;
      if (txState_r == TX_IDLE)
      begin
        if (ackFire || hostGo)
        begin
          txState_r <= TX_SHR;
          shrCnt_r  <= '0;
          txIdx_r   <= '0;
          octTmr_r  <= '0;
          txAck_r   <= ackFire;
          txLen_r   <= ackFire ? hdr_rate_pkg::ACK_LEN : dat_i[6:0];
        end
      end
      else if (!octDue)
      begin
        octTmr_r <= octTmr_r - 13'h0001;
      end
      else
      begin
        octTmr_r           <= octLoad;
        txOut.octStrobe    <= txState_r != TX_PAY || txIdx_r != txLen_r;
        txOut.isAck        <= txAck_r;
        txOut.payloadPhase <= txState_r == TX_PAY;
        case (txState_r)
          TX_SHR:
          begin
            txOut.octData <= shrByte;
            shrCnt_r      <= shrCnt_r + 3'h1;
            if (shrCnt_r == 3'(hdr_rate_pkg::SHR_OCTETS - 1))
            begin
              txState_r <= TX_PHR;
            end
          end
          TX_PHR:
          begin
            txOut.octData <= phrByte;
            txState_r     <= TX_PAY;
          end
          default:
          begin
            txOut.octData <= payByte;
            txIdx_r       <= txIdx_r + 7'h01;
            if (txIdx_r == txLen_r)
            begin
              txState_r <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // rx acceptance
  wire         belowThr  = thr_r != 4'h0 && rxIn.rssi < thr_r;
  wire         takeHdr   = rxIn.hdrDet && !belowThr;
  wire         weakDrop  = thr_r == 4'h0 && highRate && rxIn.payloadWeak;
  wire         rxDone    = rxActive_r && rxIn.frameEnd;
  wire         rxKeep    = rxDone && !weakDrop;
  wire         rejectEv  = (rxIn.hdrDet && belowThr) || (rxDone && weakDrop);
  wire [12:0]  edLoad    = highRate ? 13'(hdr_rate_pkg::ED_HDR_CYC)
                                    : 13'(hdr_rate_pkg::ED_STD_CYC);
  wire [12:0]  ackLoad   = shortAck_r ? 13'(hdr_rate_pkg::ACK_SHORT_CYC)
                                      : 13'(ACK_STD_CYC);

  always_ff @(posedge clk_sys)
  begin
    if (rxActive_r && rxIn.octValid)
    begin
      fb[wrIdx_r] <= rxIn.octData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rxActive_r   <= 1'b0;
      frameValid_r <= 1'b0;
      rxLen_r      <= '0;
      wrIdx_r      <= '0;
      rxStatus_r   <= '0;
      rejectCnt_r  <= '0;
      edTmr_r      <= '0;
      edOn_r       <= 1'b0;
      edVal_r      <= '0;
      ackPend_r    <= 1'b0;
      ackTmr_r     <= '0;
      ackSeq_r     <= '0;
    end
    else
    begin
      if (takeHdr)
      begin
        rxActive_r <= 1'b1;
        rxLen_r    <= rxIn.frameLen;
        wrIdx_r    <= '0;
        edOn_r     <= 1'b1;
        edTmr_r    <= edLoad;
      end
      else if (rxActive_r && rxIn.octValid)
      begin
        wrIdx_r <= wrIdx_r + 7'h01;
      end
      if (rxDone)
      begin
        rxActive_r <= 1'b0;
      end
      if (rejectEv)
      begin
        rejectCnt_r <= rejectCnt_r + 8'h01;
      end
      if (rxKeep)
      begin
        frameValid_r <= 1'b1;
        rxStatus_r   <= {rxIn.crcOk, 7'h00};
      end
      if (edOn_r && !takeHdr)
      begin
        edTmr_r <= edTmr_r - 13'h0001;
        if (edTmr_r == 13'h0001)
        begin
          edOn_r  <= 1'b0;
          edVal_r <= rxIn.edLevel;
        end
      end
      if (rxKeep && autoAck_r && rxIn.ackReq && !ackPend_r)
      begin
        ackPend_r <= 1'b1;
        ackTmr_r  <= ackLoad;
        ackSeq_r  <= rxIn.seqNum;
      end
      else if (ackFire)
      begin
        ackPend_r <= 1'b0;
      end
      else if (ackPend_r && ackTmr_r != 13'h0001)
      begin
        ackTmr_r <= ackTmr_r - 13'h0001;
      end
    end
  end

  // buffer read sequencer
  rd_state_t   rdState_r;
  logic [6:0]  rdIdx_r;
  wire         rdGo     = wbWr && selCmd && sel_i[0] && dat_i[7:5] == hdr_rate_pkg::FB_READ_CMD;
  wire [7:0]   statByte = {frameValid_r, rxActive_r, txBusy, ackPend_r, 2'b00, rate_r};
  wire [7:0]   rdByte   = rdState_r == RD_STAT ? statByte :
                          rdState_r == RD_PHR  ? {1'b0, rxLen_r} :
                          rdState_r == RD_PAY  ? fb[rdIdx_r] :
                          rdState_r == RD_LQI  ? hdr_rate_pkg::LQI_FILL :
                          rdState_r == RD_ED   ? edVal_r : rxStatus_r;
  wire         rdPush   = rdState_r != RD_IDLE && fifoInReady;
  wire         payLast  = rdIdx_r + 7'h01 >= rxLen_r;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rdState_r <= RD_IDLE;
      rdIdx_r   <= '0;
    end
    else if (rdState_r == RD_IDLE)
    begin
      if (rdGo)
      begin
        rdState_r <= RD_STAT;
        rdIdx_r   <= '0;
      end
    end
    else if (rdPush)
    begin
      case (rdState_r)
        RD_STAT: rdState_r <= RD_PHR;
        RD_PHR:  rdState_r <= rxLen_r == 7'h00 ? RD_LQI : RD_PAY;
        RD_PAY:
        begin
          rdIdx_r <= rdIdx_r + 7'h01;
          if (payLast)
          begin
            rdState_r <= RD_LQI;
          end
        end
        RD_LQI:  rdState_r <= RD_ED;
        RD_ED:   rdState_r <= RD_RXS;
        default: rdState_r <= RD_IDLE;
      endcase
    end
  end

  byte_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inValid  (rdPush),
    .inData   (rdByte),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (popData)
  );

  // register writes and read answer
  wire [31:0]  ctrlRd = {12'h000, ccaMode_r, shortAck_r, autoAck_r, 4'h0, thr_r,
                         2'b00, scramEn_r, 2'b00, 1'b0, rate_r};
  wire [31:0]  statRd = {8'h00, rejectCnt_r, edVal_r, 3'b000, edOn_r, ackPend_r, txBusy,
                         rxActive_r, frameValid_r};
  wire [31:0]  dataRd = {23'h000000, fifoOutValid, fifoOutData};
  wire [31:0]  rdMux  = selCtrl ? ctrlRd : selStat ? statRd : selData ? dataRd : 32'h00000000;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rate_r     <= hdr_rate_pkg::RATE_RESET;
      scramEn_r  <= hdr_rate_pkg::SCRAM_RESET;
      thr_r      <= '0;
      autoAck_r  <= 1'b0;
      shortAck_r <= 1'b0;
      ccaMode_r  <= hdr_rate_pkg::CCA_RESET;
      ack_r      <= 1'b0;
      dat_r      <= '0;
    end
    else
    begin
      ack_r <= wbReq;
      if (wbRd)
      begin
        dat_r <= rdMux;
      end
      if (wrCtrl0 && rateOk)
      begin
        rate_r <= rateWr[1:0];
      end
      if (wrCtrl0)
      begin
        scramEn_r <= dat_i[hdr_rate_pkg::CTRL_SCRAM_BIT];
      end
      if (wrCtrl1)
      begin
        thr_r <= dat_i[hdr_rate_pkg::CTRL_THR_LSB +: 4];
      end
      if (wrCtrl2)
      begin
        autoAck_r  <= dat_i[hdr_rate_pkg::CTRL_AACK_BIT];
        shortAck_r <= dat_i[hdr_rate_pkg::CTRL_SACK_BIT];
        ccaMode_r  <= dat_i[hdr_rate_pkg::CTRL_CCA_LSB +: 2];
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // modem configuration, rate applies to both directions
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      phyCfg <= '0;
    end
    else
    begin
      phyCfg.rate     <= rate_r;
      phyCfg.scramble <= rate_r == hdr_rate_pkg::RATE_2000 && scramEn_r;
      phyCfg.ccaMode  <= highRate ? hdr_rate_pkg::CCA_ENERGY : ccaMode_r;
      phyCfg.edWindow <= edOn_r;
    end
  end
endmodule

// [dv/hdr_rate_framer_assertions.sv]
// port assertions for the high data rate framer
`timescale 1ns/10ps
module hdr_rate_framer_assertions #(
  parameter int ACK_STD_CYC = 4800
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  // wishbone
  input wire logic                   cyc_i,
  input wire logic                   stb_i,
  input wire logic                   we_i,
  input wire logic [7:0]             adr_i,
  input wire logic [31:0]            dat_i,
  input wire logic [3:0]             sel_i,
  input wire logic [31:0]            dat_o,
  input wire logic                   ack_o,
  // radio side
  input wire hdr_rate_pkg::rx_in_t   rxIn,
  input wire logic [7:0]             txPayloadData,
  input wire hdr_rate_pkg::tx_out_t  txOut,
  input wire hdr_rate_pkg::phy_cfg_t phyCfg
);
  logic [12:0] gapCnt_r;
  logic [11:0] edCnt_r;
  logic [2:0]  ackOct_r;
  logic        lastHdr_r;

  // cycles since last octet strobe and kind of that strobe
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      gapCnt_r <= 13'h1fff;
    else if (txOut.octStrobe)
      gapCnt_r <= 13'h1;
    else if (gapCnt_r != 13'h1fff)
      gapCnt_r <= gapCnt_r + 13'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      lastHdr_r <= 1'b0;
    else if (txOut.octStrobe)
      lastHdr_r <= !txOut.payloadPhase;
  end
  // energy window length and ack payload count
  always_ff @(posedge clk_sys)
  begin
    edCnt_r <= phyCfg.edWindow ? edCnt_r + 12'h1 : 12'h0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || (txOut.octStrobe && !txOut.payloadPhase))
      ackOct_r <= 3'h0;
    else if (txOut.octStrobe && txOut.isAck)
      ackOct_r <= ackOct_r + 3'h1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence busReq;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ackPulse;
    ack_o ##1 !ack_o;
  endsequence

  ack_time_a: assert property (busReq |=> ackPulse)
    else $error("ack not a single pulse one cycle after request");
  read_data_a: assert property ($changed(dat_o) |-> ack_o)
    else $error("read data changed without ack");
  rate_src_a: assert property ($changed(phyCfg.rate) |-> $past(we_i) || $past(we_i, 2))
    else $error("rate changed without a bus write");
  hdr_gap_a: assert property (txOut.octStrobe && !txOut.payloadPhase && lastHdr_r
    |-> gapCnt_r == 13'h320)
    else $error("header octet spacing not 800 cycles");
  pay_gap_a: assert property (txOut.octStrobe && txOut.payloadPhase
    |-> gapCnt_r == (13'h320 >> phyCfg.rate))
    else $error("payload octet spacing wrong for rate");
  ack_len_a: assert property (txOut.octStrobe && txOut.payloadPhase && txOut.isAck
    |-> ackOct_r < 3'h5)
    else $error("ack payload longer than five octets");
  ed_len_a: assert property ($fell(phyCfg.edWindow)
    |-> edCnt_r == ((phyCfg.rate != 2'h0) ? 12'h320 : 12'hc80))
    else $error("energy window length wrong");
  scram_a: assert property (phyCfg.scramble |-> phyCfg.rate == hdr_rate_pkg::RATE_2000)
    else $error("scrambling outside top rate");
  cca_a: assert property (phyCfg.rate != 2'h0 |-> phyCfg.ccaMode == hdr_rate_pkg::CCA_ENERGY)
    else $error("carrier sense mode at high rate");
endmodule

bind hdr_rate_framer hdr_rate_framer_assertions #(.ACK_STD_CYC(ACK_STD_CYC)) chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .dat_i(dat_i),
  .sel_i(sel_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .rxIn(rxIn),
  .txPayloadData(txPayloadData),
  .txOut(txOut),
  .phyCfg(phyCfg)
);

// [dv/rf_peer_model.sv]
// radio side model: receive events and transmit payload byte
`timescale 1ns/10ps
module rf_peer_model (
  // clock
  input  wire logic            clk_sys,
  // framer side
  output hdr_rate_pkg::rx_in_t rxIn,
  output logic [7:0]           txPayloadData
);
  time endT;

  initial
  begin
    rxIn = '0;
    txPayloadData = 8'h00;
    endT = 0;
  end

  task pay(input logic [7:0] b);
    @(posedge clk_sys);
    txPayloadData <= b;
  endtask

  // header event, payload octets, end event
  task frame(input logic [6:0] len, input logic [3:0] rs, input logic wk,
             input logic ar, input logic [7:0] sq, input logic [7:0] ed);
    @(posedge clk_sys);
    rxIn.hdrDet <= 1'b1;
    rxIn.frameLen <= len;
    rxIn.rssi <= rs;
    rxIn.edLevel <= ed;
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk_sys);
      rxIn.hdrDet <= 1'b0;
      rxIn.octValid <= 1'b1;
      rxIn.octData <= 8'h40 + 8'(i);
      @(posedge clk_sys);
      rxIn.octValid <= 1'b0;
      rxIn.octData <= ~rxIn.octData;
    end
    @(posedge clk_sys);
    rxIn.hdrDet <= 1'b0;
    rxIn.frameEnd <= 1'b1;
    rxIn.crcOk <= 1'b1;
    rxIn.payloadWeak <= wk;
    rxIn.ackReq <= ar;
    rxIn.seqNum <= sq;
    endT = $time;
    @(posedge clk_sys);
    rxIn.frameEnd <= 1'b0;
  endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the high data rate framer
`timescale 1ns/10ps
`define CHK(a, e) \
  begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("FAIL %0t got %h want %h", $time, (a), (e)); end end
module tb;
  localparam int ACKC = 4800;
  logic                   clk_sys;
  logic                   resetn;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic                   ack;
  logic [3:0]             sel;
  logic [7:0]             adr;
  logic [7:0]             txPay;
  logic [7:0]             rj;
  logic [31:0]            dat;
  logic [31:0]            datO;
  logic [31:0]            q;
  hdr_rate_pkg::rx_in_t   rxIn;
  hdr_rate_pkg::tx_out_t  txOut;
  hdr_rate_pkg::phy_cfg_t phyCfg;
  int                     err_count;
  int                     checks;
  int                     tick;
  time                    d;
  time                    dly;
  time                    tq[$];
  logic [7:0]             oq[$];
  logic [7:0]             bq[$];
  // reject table: control word, rssi, weak flag, wait, count step
  logic [31:0] rjCtl[4] = '{32'h00000400, 32'h00000400, 32'h00000023, 32'h00000123};
  logic [3:0]  rjRs[4] = '{4'h2, 4'h6, 4'h5, 4'h3};
  logic        rjWk[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  int          rjW[4] = '{3300, 3300, 900, 900};
  logic [7:0]  rjInc[4] = '{8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0]  ackB[5] = '{8'h02, 8'h00, 8'h5a, 8'h00, 8'h00};

  hdr_rate_framer #(.ACK_STD_CYC(ACKC), .FIFO_DEPTH(4)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(datO), .ack_o(ack), .rxIn(rxIn),
    .txPayloadData(txPay), .txOut(txOut), .phyCfg(phyCfg));
  rf_peer_model peer (.clk_sys(clk_sys), .rxIn(rxIn), .txPayloadData(txPay));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    tick <= tick + 1;
    if (txOut.octStrobe === 1'b1)
    begin
      oq.push_back(txOut.octData);
      tq.push_back($time);
    end
    if (tick == 90000)
    begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // start a buffer read, let the fifo fill and stall, drain to empty
  task fbRead(input int n);
    bq = {};
    wb(1'b1, hdr_rate_pkg::REG_FBCMD, 32'h20);
    repeat (12) @(posedge clk_sys);
    while (bq.size() < n)
    begin
      wb(1'b0, hdr_rate_pkg::REG_FBDATA, 32'h0);
      if (q[8] === 1'b1)
        bq.push_back(q[7:0]);
    end
    wb(1'b0, hdr_rate_pkg::REG_FBDATA, 32'h0);
    `CHK(q[8], 1'b0)
  endtask

  initial
  begin
    resetn = 1'b0;
    {cyc, stb, we, adr, dat, tick, err_count, checks} = '0;
    sel = 4'hf;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    wb(1'b0, hdr_rate_pkg::REG_CTRL, 32'h0);
    `CHK(q, 32'h00040020)
    `CHK(phyCfg, 6'h02)
    wb(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h0)
    $display("test reset done");
    for (int r = 0; r < 4; r++)
    begin
      peer.pay(8'h90 + 8'(r));
      wb(1'b1, hdr_rate_pkg::REG_CTRL, 32'h00080020 | 32'(r));
      wb(1'b1, hdr_rate_pkg::REG_CTRL, 32'h00080025);
      wb(1'b0, hdr_rate_pkg::REG_CTRL, 32'h0);
      `CHK(q[2:0], 3'(r))
      `CHK(phyCfg.rate, 2'(r))
      `CHK(phyCfg.scramble, r == 3)
      `CHK(phyCfg.ccaMode, (r != 0) ? 2'h1 : 2'h2)
      oq = {};
      tq = {};
      do wb(1'b0, hdr_rate_pkg::REG_STATUS, 32'h0); while (q[2] !== 1'b0);
      wb(1'b1, hdr_rate_pkg::REG_TXCTRL, 32'h102);
      while (oq.size() < 8) @(posedge clk_sys);
      for (int i = 0; i < 4; i++)
        `CHK(oq[i], 8'h00)
      `CHK(oq[4], 8'ha7)
      `CHK(oq[5], 8'h02)
      `CHK(oq[6], 8'h90 + 8'(r))
      `CHK(oq[7], 8'h90 + 8'(r))
      `CHK((tq[5] - tq[4]) / 40, 64'd800)
      `CHK((tq[6] - tq[5]) / 40, 64'd800 >> r)
      `CHK((tq[7] - tq[6]) / 40, 64'd800 >> r)
    end
    wb(1'b1, hdr_rate_pkg::REG_CTRL, 32'h00000003);
    wb(1'b0, hdr_rate_pkg::REG_CTRL, 32'h0);
    `CHK(phyCfg.scramble, 1'b0)
    $display("test rates done");
    wb(1'b1, hdr_rate_pkg::REG_CTRL, 32'h00000021);
    peer.frame(7'h2, 4'h5, 1'b0, 1'b0, 8'h00, 8'h3c);
    repeat (900) @(posedge clk_sys);
    fbRead(7);
    `CHK(bq[0][1:0], 2'h1)
    `CHK(bq[1], 8'h02)
    `CHK(bq[2], 8'h40)
    `CHK(bq[3], 8'h41)
    `CHK(bq[4], 8'hff)
    `CHK(bq[5], 8'h3c)
    `CHK(bq[6], 8'h80)
    $display("test buffer read done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, hdr_rate_pkg::REG_CTRL, rjCtl[i]);
      wb(1'b0, hdr_rate_pkg::REG_STATUS, 32'h0);
      rj = q[23:16];
      peer.frame(7'h2, rjRs[i], rjWk[i], 1'b0, 8'h00, 8'h3c);
      repeat (rjW[i]) @(posedge clk_sys);
      wb(1'b0, hdr_rate_pkg::REG_STATUS, 32'h0);
      `CHK(q[23:16], rj + rjInc[i])
    end
    $display("test reject done");
    for (int s = 0; s < 2; s++)
    begin
      wb(1'b1, hdr_rate_pkg::REG_CTRL, 32'h00010021 | (32'(s) << 17));
      oq = {};
      tq = {};
      peer.frame(7'h1, 4'h5, 1'b0, 1'b1, 8'h5a, 8'h11);
      while (oq.size() < 11) @(posedge clk_sys);
      d = (tq[0] - peer.endT) / 40;
      dly = (s == 1) ? hdr_rate_pkg::ACK_SHORT_CYC : ACKC;
      `CHK(d >= dly && d <= dly + 4, 1'b1)
      `CHK(oq[5], 8'h05)
      for (int i = 0; i < 5; i++)
        `CHK(oq[6 + i], ackB[i])
      repeat (1000) @(posedge clk_sys);
      `CHK(oq.size(), 11)
    end
    $display("test ack done");
    wrap_up();
  end
endmodule
